// ===== verilog/bss_defines.vh
// Purpose: Constants shared by the brew step sequencer.
// Assumes: 100 MHz clock, 10 ns period.
// Notes: AXI4-Lite register offsets are byte addresses.
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH
`define BSS_CLK_HZ          100000000
`define BSS_HOLDSTOP_S      5
`define BSS_HOLDSTOP_CYC    33'h0_1DCD_6500
`define BSS_REVERT_S        2
`define BSS_REVERT_CYC      33'h0_0BEB_C200
`define BSS_ALT_CYC         33'h0_05F5_E100
`define BSS_MIN_CYC         33'h1_65A0_BC00
`define BSS_REG_CTRL        8'h00
`define BSS_REG_STATUS      8'h04
`define BSS_REG_TEMP        8'h08
`define BSS_REG_SETPT       8'h0C
`define BSS_REG_POWER       8'h10
`define BSS_REG_BOILCFG     8'h14
`define BSS_REG_STEP0       8'h20
`define BSS_CTRL_RESET      32'h0000_0000
`define BSS_BOILCFG_RESET   32'h0000_0000
`define BSS_POWER_RESET     7'h32
`define BSS_DUR_HOLD        12'hFFE
`define BSS_DUR_STOP        12'hFFF
`define BSS_ST_STOP         3'h0
`define BSS_ST_WAIT         3'h1
`define BSS_ST_RUN          3'h2
`define BSS_ST_HOLD         3'h3
`define BSS_ST_END          3'h4
`define BSS_MN_IDLE         2'h0
`define BSS_MN_OPEN         2'h1
`endif

// ===== verilog/bss_sequencer.v
// Purpose: Brew step sequencer: mash program, boil power, keys, knob menu, AXI4-Lite registers.
// Assumes: Keys, knob and sensor-open inputs are pins and are synchronised here.
// Notes: Mode is restored from a nonvolatile input captured after reset release.
//
// Contract
// RULE_01 - Short knob press opens menu; two clicks reach mode page; press applies mode.
// RULE_02 - Mash lamp on in mashing mode, off in boiling mode.
// RULE_03 - Pressing the knob on the exit option leaves menu, nothing changed.
// RULE_04 - At power-up restore the mode active when power was lost.
// RULE_05 - Open sensor shows open message and forces heater off.
// RULE_06 - Mashing with countdown running alternates temperature and step time remaining.
// RULE_07 - Mashing heats fully on, then modulated reduced duty near set point.
// RULE_08 - Program holds six set-point and hh:mm duration entries in order.
// RULE_09 - Durations below zero select the hold or stop values.
// RULE_10 - Hold step regulates at its set point until run key; uses a slot.
// RULE_11 - Hold keeps set point; boil hold pauses timer, power adjustable; run resumes.
// RULE_12 - Stop halts program and heater whatever the state; run key restarts.
// RULE_13 - After stop the program restarts only from the first step.
// RULE_14 - Zero duration step ends program; end option chooses heating or not.
// RULE_15 - From end, menu reset converts end to stop; then run key restarts.
// RULE_16 - Run starts; short hold/stop press holds; five-second press stops and flashes.
// RULE_17 - Hold requested before timer start: timer starts held, with beep, inside band.
// RULE_18 - Relays set per step, or follow the beeper at step start and end.
// RULE_19 - Mash knob turn edits set point temporarily; press confirms; reverts after two seconds.
// RULE_20 - Boil knob turn changes power percentage at once, shown with prefix.
// RULE_21 - During acceleration new power shown but applied later; zero threshold means manual.
// RULE_22 - Boiling timer running alternates temperature and total remaining time.
`timescale 1ns/10ps
`include "bss_defines.vh"
module bss_sequencer #(
	parameter [32:0] HOLDSTOP_CYC = `BSS_HOLDSTOP_CYC,
	parameter [32:0] REVERT_CYC   = `BSS_REVERT_CYC,
	parameter [32:0] ALT_CYC      = `BSS_ALT_CYC,
	parameter [32:0] MIN_CYC      = `BSS_MIN_CYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Panel pins
	input  wire        knobPress,
	input  wire        knobCw,
	input  wire        knobCcw,
	input  wire        runKey,
	input  wire        holdStopKey,
	input  wire        sensorOpen,
	input  wire        savedModeMash,
	// Panel and load outputs
	output reg         mashLamp,
	output reg         heaterOut,
	output reg  [1:0]  relayOut,
	output reg         beep,
	output reg         pendingDot,
	output reg  [2:0]  topShow,
	output reg  [2:0]  bottomShow,
	output reg  [11:0] topValue,
	output reg         modeRetain
);
	// Sync: two flops per pin; edges compare stage two with a third flop holding its previous value.
	reg [6:0] s1_q;
	reg [6:0] s2_q;
	reg [6:0] p_q;
	wire [6:0] pinRaw = {savedModeMash, sensorOpen, holdStopKey, runKey, knobCcw, knobCw, knobPress};
	always @(posedge clk) begin
		s1_q <= pinRaw;
		s2_q <= s1_q;
		p_q  <= s2_q;
	end
	wire [6:0] rise = s2_q & ~p_q;
	wire pressEv = rise[0];
	wire cwEv    = rise[1];
	wire ccwEv   = rise[2];
	wire runEv   = rise[3];
	wire hsLevel = s2_q[4];
	wire hsFall  = p_q[4] & ~s2_q[4];
	wire snsOpen = s2_q[5];

	// Registers.
	reg        mash_q;
	reg        loaded_q;
	reg [31:0] ctrl_q;
	reg [11:0] temp_q;
	reg [11:0] setSw_q;
	reg [6:0]  power_q;
	reg [6:0]  applied_q;
	reg [31:0] boilCfg_q;
	reg [11:0] stepSp_q [0:5];
	reg [11:0] stepDur_q [0:5];
	reg [1:0]  stepRly_q [0:5];
	reg [2:0]  st_q;
	reg [2:0]  step_q;
	reg [11:0] remain_q;
	reg [32:0] minCnt_q;
	reg [32:0] hsCnt_q;
	reg        hsDone_q;
	reg        holdReq_q;
	reg [11:0] tmpSp_q;
	reg [32:0] revCnt_q;
	reg [1:0]  menu_q;
	reg [1:0]  click_q;
	reg [32:0] altCnt_q;
	reg        alt_q;
	reg [3:0]  pwm_q;
	reg [15:0] boilLeft_q;

	wire endOpt     = ctrl_q[1];
	wire boilEndOpt = ctrl_q[2];
	wire relayBeep  = ctrl_q[3];
	wire [7:0] band = ctrl_q[15:8];
	wire [11:0] accelThr = boilCfg_q[11:0];
	wire timerEn    = boilCfg_q[12];
	wire [11:0] curSp = pendingDot ? tmpSp_q : setSw_q;
	wire [11:0] diff = (curSp > temp_q) ? curSp - temp_q : temp_q - curSp;
	wire inBand = diff < {4'h0, band};
	wire accel = (accelThr != 12'h000) && (temp_q < accelThr); // [RULE_21]
	wire [11:0] durNow = stepDur_q[step_q];

	// Duration to minutes: hh in [11:6], mm in [5:0].
	function [11:0] toMin;
		input [11:0] d;
		toMin = d[11:6] * 12'h03C + {6'h00, d[5:0]};
	endfunction

	// AXI4-Lite slave, one write and one read at a time.
	reg [7:0]  aw_q;
	reg [31:0] w_q;
	reg        awHave_q;
	reg        wHave_q;
	wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
	wire wStep = aw_q >= `BSS_REG_STEP0 && aw_q < `BSS_REG_STEP0 + 8'h18;
	wire [2:0] wIdx = aw_q[4:2];
	wire wMapped = wStep || aw_q == `BSS_REG_CTRL || aw_q == `BSS_REG_TEMP ||
		aw_q == `BSS_REG_SETPT || aw_q == `BSS_REG_POWER || aw_q == `BSS_REG_BOILCFG;
	always @(posedge clk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			awHave_q      <= 1'b0;
			wHave_q       <= 1'b0;
			aw_q          <= 8'h00;
			w_q           <= 32'h0000_0000;
		end else begin
			s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !wHave_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awready && s_axi_awvalid) begin
				awHave_q <= 1'b1;
				aw_q     <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wHave_q <= 1'b1;
				w_q     <= s_axi_wdata;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wMapped ? 2'h0 : 2'h2;
				awHave_q     <= 1'b0;
				wHave_q      <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	wire [2:0] rIdx = s_axi_araddr[4:2];
	wire rStep = s_axi_araddr >= `BSS_REG_STEP0 && s_axi_araddr < `BSS_REG_STEP0 + 8'h18;
	always @(posedge clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (rStep)
					s_axi_rdata <= {2'h0, stepRly_q[rIdx], stepDur_q[rIdx], 4'h0, stepSp_q[rIdx]};
				else case (s_axi_araddr)
				`BSS_REG_CTRL:    s_axi_rdata <= ctrl_q;
				`BSS_REG_STATUS:  s_axi_rdata <= {16'h0000, remain_q, mash_q, st_q};
				`BSS_REG_TEMP:    s_axi_rdata <= {20'h00000, temp_q};
				`BSS_REG_SETPT:   s_axi_rdata <= {20'h00000, curSp};
				`BSS_REG_POWER:   s_axi_rdata <= {17'h00000, applied_q, 1'b0, power_q};
				`BSS_REG_BOILCFG: s_axi_rdata <= boilCfg_q;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Step table, eight-bit-lane writes are not split: a word write replaces the entry.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : gStep
			always @(posedge clk) begin
				if (!rst_b) begin
					stepSp_q[gi]  <= 12'h000;
					stepDur_q[gi] <= 12'h000;
					stepRly_q[gi] <= 2'h0;
				end else if (doWrite && wStep && wIdx == gi) begin // [RULE_08] [RULE_09]
					stepSp_q[gi]  <= w_q[11:0];
					stepDur_q[gi] <= w_q[27:16];
					stepRly_q[gi] <= w_q[29:28];
				end
			end
		end
	endgenerate

	// Sequencer, menu, keys and knob.
	always @(posedge clk) begin
		if (!rst_b) begin
			mash_q <= 1'b1;
			loaded_q <= 1'b0;
			ctrl_q <= `BSS_CTRL_RESET;
			boilCfg_q <= `BSS_BOILCFG_RESET;
			temp_q <= 12'h000;
			setSw_q <= 12'h000;
			power_q <= `BSS_POWER_RESET;
			applied_q <= `BSS_POWER_RESET;
			st_q <= `BSS_ST_STOP;
			step_q <= 3'h0;
			remain_q <= 12'h000;
			minCnt_q <= 33'h0_0000_0000;
			hsCnt_q <= 33'h0_0000_0000;
			hsDone_q <= 1'b0;
			holdReq_q <= 1'b0;
			tmpSp_q <= 12'h000;
			revCnt_q <= 33'h0_0000_0000;
			pendingDot <= 1'b0;
			menu_q <= `BSS_MN_IDLE;
			click_q <= 2'h0;
			beep <= 1'b0;
			boilLeft_q <= 16'h0000;
		end else begin
			beep <= 1'b0;
			if (!loaded_q) begin
				loaded_q <= 1'b1;
				mash_q <= s2_q[6]; // [RULE_04]
			end
			if (doWrite && aw_q == `BSS_REG_CTRL)
				ctrl_q <= w_q;
			if (doWrite && aw_q == `BSS_REG_TEMP)
				temp_q <= w_q[11:0];
			if (doWrite && aw_q == `BSS_REG_SETPT)
				setSw_q <= w_q[11:0];
			if (doWrite && aw_q == `BSS_REG_BOILCFG)
				boilCfg_q <= w_q;
			// Hold/stop key: short release holds, five seconds stops once.
			if (hsLevel) begin
				if (hsCnt_q == HOLDSTOP_CYC - 33'h1) begin
					hsDone_q <= 1'b1;
					st_q <= `BSS_ST_STOP; // [RULE_16] [RULE_12]
					step_q <= 3'h0; // [RULE_13]
				end
				if (!hsDone_q)
					hsCnt_q <= hsCnt_q + 33'h1;
			end else begin
				hsCnt_q <= 33'h0_0000_0000;
				hsDone_q <= 1'b0;
			end
			if (hsFall && !hsDone_q) begin
				if (st_q == `BSS_ST_RUN)
					st_q <= `BSS_ST_HOLD; // [RULE_16] [RULE_11]
				else if (st_q == `BSS_ST_WAIT)
					holdReq_q <= 1'b1; // [RULE_17]
			end
			if (runEv) begin
				// Each step regulates at its own stored set point; a confirmed edit lasts until the next step.
				if (st_q == `BSS_ST_STOP) begin
					st_q <= `BSS_ST_WAIT; // [RULE_12] [RULE_13]
					step_q <= 3'h0;
					setSw_q <= stepSp_q[0];
					holdReq_q <= 1'b0;
				end else if (st_q == `BSS_ST_HOLD) begin
					if (durNow == `BSS_DUR_HOLD)
						st_q <= (step_q == 3'h5) ? `BSS_ST_END : `BSS_ST_WAIT; // [RULE_10]
					else
						st_q <= `BSS_ST_RUN; // [RULE_11]
					if (durNow == `BSS_DUR_HOLD && step_q != 3'h5) begin
						step_q <= step_q + 3'h1;
						setSw_q <= stepSp_q[step_q + 3'h1]; // [RULE_10]
					end
				end
			end
			// Step entry and countdown.
			if (mash_q && st_q == `BSS_ST_WAIT) begin
				if (durNow == 12'h000)
					st_q <= `BSS_ST_END; // [RULE_14]
				else if (durNow == `BSS_DUR_STOP) begin
					st_q <= `BSS_ST_STOP; // [RULE_13]
					step_q <= 3'h0;
				end else if (durNow == `BSS_DUR_HOLD)
					st_q <= `BSS_ST_HOLD; // [RULE_10]
				else if (inBand && !beep) begin
					// A hold press in the very cycle the timer starts still counts.
					st_q <= (holdReq_q || (hsFall && !hsDone_q)) ? `BSS_ST_HOLD : `BSS_ST_RUN; // [RULE_17]
					holdReq_q <= 1'b0;
					remain_q <= toMin(durNow);
					minCnt_q <= 33'h0_0000_0000;
					beep <= 1'b1; // [RULE_18]
				end
			end
			if (mash_q && st_q == `BSS_ST_RUN) begin
				if (minCnt_q == MIN_CYC - 33'h1) begin
					minCnt_q <= 33'h0_0000_0000;
					if (remain_q <= 12'h001) begin
						beep <= 1'b1; // [RULE_18]
						st_q <= (step_q == 3'h5) ? `BSS_ST_END : `BSS_ST_WAIT;
						if (step_q != 3'h5) begin
							step_q <= step_q + 3'h1;
							setSw_q <= stepSp_q[step_q + 3'h1]; // [RULE_08]
						end
					end else
						remain_q <= remain_q - 12'h001;
				end else
					minCnt_q <= minCnt_q + 33'h1;
			end
			// Boil: timer runs only when enabled; hold pauses it but power stays.
			if (!mash_q && st_q == `BSS_ST_WAIT)
				st_q <= `BSS_ST_RUN;
			if (!mash_q && st_q == `BSS_ST_RUN && timerEn) begin // [RULE_11]
				boilLeft_q <= boilCfg_q[31:16];
				if (minCnt_q == MIN_CYC - 33'h1) begin
					minCnt_q <= 33'h0_0000_0000;
					if (boilCfg_q[31:16] != 16'h0000)
						boilCfg_q[31:16] <= boilCfg_q[31:16] - 16'h0001;
					else
						st_q <= `BSS_ST_END;
				end else
					minCnt_q <= minCnt_q + 33'h1;
			end
			if (!accel)
				applied_q <= power_q; // [RULE_21]
			// Temporary set point revert.
			if (pendingDot) begin
				if (revCnt_q == REVERT_CYC - 33'h1)
					pendingDot <= 1'b0; // [RULE_19]
				else
					revCnt_q <= revCnt_q + 33'h1;
			end
			// Knob: menu first, else set point or power.
			case (menu_q)
			`BSS_MN_IDLE: begin
				if (pressEv && pendingDot) begin
					setSw_q <= tmpSp_q; // [RULE_19]
					pendingDot <= 1'b0;
				end else if (pressEv) begin
					menu_q <= `BSS_MN_OPEN; // [RULE_01]
					click_q <= 2'h0;
				end else if (cwEv || ccwEv) begin
					if (mash_q) begin
						tmpSp_q <= (pendingDot ? tmpSp_q : setSw_q) + (cwEv ? 12'h001 : 12'hFFF); // [RULE_19]
						pendingDot <= 1'b1;
						revCnt_q <= 33'h0_0000_0000;
					end else if (cwEv && power_q < 7'h64)
						power_q <= power_q + 7'h01; // [RULE_20]
					else if (ccwEv && power_q != 7'h00)
						power_q <= power_q - 7'h01; // [RULE_20]
				end
			end
			`BSS_MN_OPEN: begin
				// Page 0 exit, 1 reset to stop, 2 mash, 3 boil.
				if (cwEv && click_q != 2'h3)
					click_q <= click_q + 2'h1;
				else if (ccwEv && click_q != 2'h0)
					click_q <= click_q - 2'h1;
				else if (pressEv) begin
					menu_q <= `BSS_MN_IDLE; // [RULE_03]
					if (click_q == 2'h1) begin
						st_q <= `BSS_ST_STOP; // [RULE_15]
						step_q <= 3'h0;
					end else if (click_q[1]) begin
						mash_q <= ~click_q[0]; // [RULE_01]
						st_q <= `BSS_ST_STOP;
						step_q <= 3'h0;
					end
				end
			end
			default: menu_q <= `BSS_MN_IDLE;
			endcase
		end
	end

	// Outputs: display selection, heater and relays.
	wire endHeat = mash_q ? endOpt : boilEndOpt;
	wire heatAllowed = !snsOpen && st_q != `BSS_ST_STOP && (st_q != `BSS_ST_END || endHeat); // [RULE_05] [RULE_12] [RULE_14]
	wire [3:0] duty = mash_q ? (inBand ? diff[3:0] : 4'hF) : applied_q[6:3]; // [RULE_07]
	always @(posedge clk) begin
		if (!rst_b) begin
			altCnt_q <= 33'h0_0000_0000;
			alt_q <= 1'b0;
			pwm_q <= 4'h0;
			mashLamp <= 1'b0;
			heaterOut <= 1'b0;
			relayOut <= 2'h0;
			topShow <= 3'h0;
			bottomShow <= 3'h0;
			topValue <= 12'h000;
			modeRetain <= 1'b0;
		end else begin
			altCnt_q <= (altCnt_q == ALT_CYC - 33'h1) ? 33'h0_0000_0000 : altCnt_q + 33'h1;
			if (altCnt_q == ALT_CYC - 33'h1)
				alt_q <= ~alt_q;
			pwm_q <= pwm_q + 4'h1;
			mashLamp <= mash_q; // [RULE_02]
			modeRetain <= mash_q;
			heaterOut <= heatAllowed && (duty == 4'hF || pwm_q < duty); // [RULE_07] [RULE_05]
			relayOut <= relayBeep ? {2{beep}} : stepRly_q[step_q]; // [RULE_18]
			// Top show: 0 temperature, 1 open sensor, 2 step time, 3 boil total time.
			if (snsOpen) begin
				topShow <= 3'h1; // [RULE_05]
				topValue <= 12'h000;
			end else if (alt_q && mash_q && st_q == `BSS_ST_RUN) begin
				topShow <= 3'h2; // [RULE_06]
				topValue <= remain_q;
			end else if (alt_q && !mash_q && st_q == `BSS_ST_RUN && timerEn) begin
				topShow <= 3'h3; // [RULE_22]
				topValue <= boilLeft_q[11:0];
			end else begin
				topShow <= 3'h0;
				topValue <= temp_q;
			end
			// Bottom show: 0 set point, 1 power with prefix, 2 stop flash, 3 to 6 menu page, 7 hold.
			if (menu_q != `BSS_MN_IDLE)
				bottomShow <= {1'b0, click_q} + 3'h3;
			else if (st_q == `BSS_ST_STOP && alt_q)
				bottomShow <= 3'h2; // [RULE_16]
			else if (st_q == `BSS_ST_HOLD && alt_q)
				bottomShow <= 3'h7;
			else
				bottomShow <= mash_q ? 3'h0 : 3'h1; // [RULE_20]
		end
	end
endmodule

// ===== sim/bss_seq_monitor.sv
// Purpose: Port-level checks for the brew step sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every bss_sequencer instance.
`timescale 1ns/10ps
module bss_seq_monitor #(
	parameter [32:0] REVERT_CYC = 33'hA
) (
	// Clock and reset
	input logic        clk,
	input logic        rst_b,
	// Bus handshakes
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	// Panel
	input logic        knobPress,
	input logic        knobCw,
	input logic        knobCcw,
	input logic        sensorOpen,
	input logic        mashLamp,
	input logic        heaterOut,
	input logic        beep,
	input logic        pendingDot,
	input logic [2:0]  topShow,
	input logic [2:0]  bottomShow
);
	logic [33:0] dotAge_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Knob activity restarts the revert window, so only an idle pending edit ages.
	always @(posedge clk) begin
		if (!rst_b || !pendingDot || knobCw || knobCcw || knobPress) begin
			dotAge_q <= 34'h0;
		end else begin
			dotAge_q <= dotAge_q + 34'h1;
		end
	end

	property p_open_off;
		sensorOpen [*6] |-> !heaterOut && topShow == 3'h1;
	endproperty
	a_open_off: assert property (p_open_off) else $error("heater on or open message missing");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read data late");
	property p_stop_off;
		bottomShow == 3'h2 [*2] |-> !heaterOut;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("heater on while stopped");
	property p_beep;
		beep |=> !beep;
	endproperty
	a_beep: assert property (p_beep) else $error("beep longer than one cycle");
	property p_dot_revert;
		dotAge_q <= {1'h0, REVERT_CYC} + 34'h8;
	endproperty
	a_dot_revert: assert property (p_dot_revert) else $error("pending edit did not revert");
	property p_mash_top;
		mashLamp [*3] |-> topShow != 3'h3;
	endproperty
	a_mash_top: assert property (p_mash_top) else $error("boil total shown in mash mode");
	property p_boil_top;
		!mashLamp [*3] |-> topShow != 3'h2 && !pendingDot;
	endproperty
	a_boil_top: assert property (p_boil_top) else $error("mash item shown in boil mode");
endmodule

bind bss_sequencer bss_seq_monitor #(.REVERT_CYC(REVERT_CYC)) i_mon (.clk, .rst_b, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .knobPress, .knobCw, .knobCcw, .sensorOpen,
	.mashLamp, .heaterOut, .beep, .pendingDot, .topShow, .bottomShow);

// ===== sim/bss_panel_model.sv
// Purpose: Operator panel model: knob, keys, sensor state and saved mode.
// Assumes: Tasks are called just after a rising clock edge.
// Notes: Each press ends with a quiet gap so the sequencer sees distinct edges.
`timescale 1ns/10ps
module bss_panel_model (
	// Clock
	input  logic clk,
	// Pins toward the sequencer
	output logic knobPress,
	output logic knobCw,
	output logic knobCcw,
	output logic runKey,
	output logic holdStopKey,
	output logic sensorOpen,
	output logic savedModeMash
);
	logic [4:0] keys_q = 5'h00;
	logic       open_q = 1'h0;
	logic       saved_q = 1'h1;

	assign {holdStopKey, runKey, knobCcw, knobCw, knobPress} = keys_q;
	assign sensorOpen = open_q;
	assign savedModeMash = saved_q;

	// A long hold/stop press is simply a large len.
	task automatic press(input int idx, input int len);
		keys_q[idx] <= 1'h1;
		repeat (len) @(posedge clk);
		keys_q[idx] <= 1'h0;
		repeat (6) @(posedge clk);
	endtask

	task automatic set_levels(input logic open, input logic saved);
		open_q <= open;
		saved_q <= saved;
	endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the brew step sequencer.
// Assumes: Short counts: hold/stop 20, revert 10, alternation 4, minute 8 cycles.
// Notes: Program state is modelled here and compared with the status register.
`timescale 1ns/10ps
`include "bss_defines.vh"
module testbench;
	localparam int LIMIT = 20000;
	localparam int KNOB = 0, CW = 1, CCW = 2, RUN = 3, HS = 4;
	// Clock, reset and register bus
	logic        clk = 1'h0, rst_b = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	// Panel
	logic        knobPress, knobCw, knobCcw, runKey, holdStopKey, sensorOpen, savedModeMash;
	logic        mashLamp, heaterOut, beep, pendingDot, modeRetain;
	logic [1:0]  relayOut;
	logic [2:0]  topShow, bottomShow;
	logic [11:0] topValue;
	// Model and bookkeeping
	int          n_mismatch = 0, checked = 0, cycles = 0, pwr = 50;
	logic        modelMash = 1'h1;
	logic [31:0] stepQ[$];

	always #5 clk = ~clk;

	bss_panel_model i_panel (.clk, .knobPress, .knobCw, .knobCcw, .runKey, .holdStopKey, .sensorOpen,
		.savedModeMash);
	bss_sequencer #(.HOLDSTOP_CYC(33'h14), .REVERT_CYC(33'hA), .ALT_CYC(33'h4), .MIN_CYC(33'h8)) i_dut (
		.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.knobPress, .knobCw, .knobCcw, .runKey, .holdStopKey, .sensorOpen, .savedModeMash, .mashLamp,
		.heaterOut, .relayOut, .beep, .pendingDot, .topShow, .bottomShow, .topValue, .modeRetain);

	task automatic give_verdict();
		$display("Comparisons: %0d, mismatches: %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			$display("unexpected at %0t: timeout", $time);
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		s_axi_bready <= 1'h1;
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  r;
		axi_rd(a, v, r);
		chk(v & m, e);
	endtask

	// Polls status under a bound, then compares mode bit and program state with the model.
	task automatic wait_state(input logic [2:0] st);
		logic [31:0] v;
		logic [1:0]  r;
		int          n;
		n = 0;
		do begin
			axi_rd(`BSS_REG_STATUS, v, r);
			n++;
		end while (v[2:0] !== st && n < 400);
		chk({28'h0, v[3:0]}, {28'h0, modelMash, st});
	endtask

	task automatic heater_off();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			chk({31'h0, heaterOut}, 32'h0);
		end
	endtask

	task automatic do_reset(input logic saved);
		rst_b <= 1'h0;
		i_panel.set_levels(1'h0, saved);
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		modelMash = saved;
		repeat (6) @(posedge clk);
	endtask

	initial begin
		logic [31:0] v;
		logic [11:0] sp, dur;
		logic [1:0]  r;
		int          n;
		n = $urandom(32'h9AC8);
		@(posedge clk);
		do_reset(1'h1);
		chk({31'h0, mashLamp}, 32'h1);
		wait_state(`BSS_ST_STOP);
		rdchk(`BSS_REG_POWER, 32'h7F7F, 32'h3232);
		sp = 12'($urandom_range(300, 100));
		for (int i = 0; i < 6; i++) begin
			dur = (i == 0) ? 12'h03F : ((i == 1) ? `BSS_DUR_HOLD : 12'h000);
			v = {2'h0, 2'(i + 1), dur, 4'h0, sp};
			stepQ.push_back(v);
			axi_wr(`BSS_REG_STEP0 + 8'(4 * i), v, r);
		end
		for (int i = 0; i < 6; i++) rdchk(`BSS_REG_STEP0 + 8'(4 * i), 32'h3FFF0FFF, stepQ[i]);
		axi_wr(`BSS_REG_TEMP, {20'h0, sp}, r);
		axi_wr(`BSS_REG_CTRL, 32'h0000_0500, r);
		axi_rd(8'hFC, v, r);
		chk({30'h0, r}, 32'h2);
		axi_wr(8'hFC, 32'hFFFF_FFFF, r);
		chk({30'h0, r}, 32'h2);
		i_panel.press(RUN, 1);
		wait_state(`BSS_ST_RUN);
		wait_state(`BSS_ST_HOLD);
		chk({30'h0, relayOut}, 32'h2);
		i_panel.press(RUN, 1);
		wait_state(`BSS_ST_END);
		heater_off();
		i_panel.press(RUN, 1);
		rdchk(`BSS_REG_STATUS, 32'h7, 32'h4);
		i_panel.press(KNOB, 1);
		i_panel.press(CW, 1);
		i_panel.press(KNOB, 1);
		wait_state(`BSS_ST_STOP);
		i_panel.press(RUN, 1);
		wait_state(`BSS_ST_RUN);
		chk({30'h0, relayOut}, 32'h1);
		i_panel.press(HS, 2);
		wait_state(`BSS_ST_HOLD);
		chk({30'h0, relayOut}, 32'h1);
		i_panel.press(RUN, 1);
		wait_state(`BSS_ST_RUN);
		i_panel.press(HS, 26);
		wait_state(`BSS_ST_STOP);
		heater_off();
		axi_wr(`BSS_REG_TEMP, 32'h0, r);
		i_panel.press(RUN, 1);
		i_panel.press(HS, 2);
		axi_wr(`BSS_REG_TEMP, {20'h0, sp}, r);
		wait_state(`BSS_ST_HOLD);
		i_panel.press(HS, 26);
		wait_state(`BSS_ST_STOP);
		i_panel.press(KNOB, 1);
		chk({29'h0, bottomShow}, 32'h3);
		i_panel.press(KNOB, 1);
		wait_state(`BSS_ST_STOP);
		chk({31'h0, mashLamp}, 32'h1);
		i_panel.press(CCW, 1);
		chk({31'h0, pendingDot}, 32'h1);
		repeat (18) @(posedge clk);
		chk({31'h0, pendingDot}, 32'h0);
		rdchk(`BSS_REG_STEP0, 32'hFFF, {20'h0, sp});
		rdchk(`BSS_REG_SETPT, 32'hFFF, {20'h0, sp});
		i_panel.press(KNOB, 1);
		i_panel.press(CW, 1);
		i_panel.press(CW, 1);
		chk({29'h0, bottomShow}, 32'h5);
		i_panel.press(CW, 1);
		i_panel.press(KNOB, 1);
		modelMash = 1'h0;
		repeat (2) @(posedge clk);
		chk({31'h0, mashLamp}, 32'h0);
		chk({31'h0, modeRetain}, 32'h0);
		wait_state(`BSS_ST_STOP);
		n = $urandom_range(6, 1);
		repeat (n) i_panel.press(CW, 1);
		pwr = pwr + n;
		rdchk(`BSS_REG_POWER, 32'h7F7F, {16'h0, 1'h0, 7'(pwr), 1'h0, 7'(pwr)});
		axi_wr(`BSS_REG_BOILCFG, 32'h0000_0FFF, r);
		i_panel.press(CW, 1);
		rdchk(`BSS_REG_POWER, 32'h7F7F, {16'h0, 1'h0, 7'(pwr), 1'h0, 7'(pwr + 1)});
		axi_wr(`BSS_REG_BOILCFG, 32'h0, r);
		pwr = pwr + 1;
		rdchk(`BSS_REG_POWER, 32'h7F7F, {16'h0, 1'h0, 7'(pwr), 1'h0, 7'(pwr)});
		i_panel.press(RUN, 1);
		i_panel.set_levels(1'h1, 1'h0);
		repeat (8) @(posedge clk);
		chk({29'h0, topShow}, 32'h1);
		heater_off();
		do_reset(1'h0);
		chk({31'h0, mashLamp}, 32'h0);
		wait_state(`BSS_ST_STOP);
		give_verdict();
	end
endmodule
